// >>> rtl/ascmc_pkg.sv
package ascmc_pkg;

  // ---------------------------------------------------------------
  // register map and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] MODE_ADDR = 16'hff50;
  localparam logic [15:0] TXBUF_ADDR = 16'hff51;
  localparam logic [15:0] RXBUF_ADDR = 16'hff52;
  localparam logic [7:0] MODE_RESET = 8'h01;
  localparam logic [7:0] RXBUF_RESET = 8'hff;
  localparam logic [7:0] TXBUF_RESET = 8'hff;

  // ---------------------------------------------------------------
  // parity encodings and timing counts
  // ---------------------------------------------------------------
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;
  localparam logic [1:0] POWER_WAIT = 2'h2;
  localparam logic [3:0] BITS_LONG = 4'h8;
  localparam logic [3:0] BITS_SHORT = 4'h7;

  // ---------------------------------------------------------------
  // mode register layout, bit 7 down to bit 0
  // ---------------------------------------------------------------
  typedef struct packed {
    logic power;
    logic tx_en;
    logic rx_en;
    logic [1:0] parity;
    logic char8;
    logic stop2;
    logic err_route;
  } ascmc_mode_s;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
  } ascmc_tx_e;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
  } ascmc_rx_e;

endpackage

// >>> rtl/ascmc_core.sv
`timescale 1ns/1ps
module ascmc_core (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_wmask,
  input wire logic bus_we,
  input wire logic bus_re,
  output logic [7:0] bus_rdata,
  input wire logic base_tick,
  input wire logic [7:0] baud_divisor,
  input wire logic msb_first,
  input wire logic error_status_read,
  input wire logic receive_pin,
  output logic transmit_pin,
  output logic transmit_buffer_full_flag,
  output logic transmit_busy,
  output logic overrun_error_flag,
  output logic parity_error_flag,
  output logic framing_error_flag,
  output logic transmit_complete_interrupt,
  output logic receive_complete_interrupt,
  output logic receive_error_interrupt
);

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  logic [7:0] serial_operation_mode;
  logic [7:0] transmit_buffer;
  logic [7:0] receive_buffer;
  ascmc_pkg::ascmc_mode_s mode;
  wire sel_mode = bus_addr == ascmc_pkg::MODE_ADDR;
  wire sel_tx = bus_addr == ascmc_pkg::TXBUF_ADDR;
  wire sel_rx = bus_addr == ascmc_pkg::RXBUF_ADDR;
  wire wr_mode = bus_we && sel_mode;
  wire wr_tx = bus_we && sel_tx;
  wire rd_rx = bus_re && sel_rx;
  wire [7:0] next_mode = (serial_operation_mode & ~bus_wmask) |
                         (bus_wdata & bus_wmask);
  wire [7:0] next_txbuf = (transmit_buffer & ~bus_wmask) |
                          (bus_wdata & bus_wmask);
  wire [7:0] rd_mux = sel_mode ? serial_operation_mode :
                      sel_tx ? transmit_buffer :
                      sel_rx ? receive_buffer : 8'h00;
  assign mode = serial_operation_mode;
  wire power = mode.power;
  wire tx_on = power && mode.tx_en;
  wire rx_on = power && mode.rx_en;
  // receive input forced high while powered down
  wire rxd = power ? receive_pin : 1'b1;
  wire [3:0] nbits = mode.char8 ? ascmc_pkg::BITS_LONG :
                     ascmc_pkg::BITS_SHORT;
  wire par_on = mode.parity != ascmc_pkg::PAR_NONE;

  // mode register, maskable write gives bit or byte access
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      serial_operation_mode <= ascmc_pkg::MODE_RESET;
    end else if (wr_mode) begin
      serial_operation_mode <= next_mode;
    end
  end

  // read data registered, unmapped addresses read zero
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bus_rdata <= 8'h00;
    end else if (bus_re) begin
      bus_rdata <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // power-up delay for the baud counters
  // ---------------------------------------------------------------
  logic [1:0] pwr_cnt;
  wire baud_ok = pwr_cnt == ascmc_pkg::POWER_WAIT;

  // counters run only from the third base clock after power-up
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pwr_cnt <= 2'h0;
    end else if (!power) begin
      pwr_cnt <= 2'h0;
    end else if (base_tick && !baud_ok) begin
      pwr_cnt <= pwr_cnt + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  ascmc_pkg::ascmc_tx_e tx_state;
  logic [7:0] tx_cnt;
  logic [7:0] transmit_shift_register;
  logic [3:0] tx_bits;
  logic tx_par;
  logic tx_stop_left;
  logic tx_full;
  wire tx_step = base_tick && baud_ok;
  wire tx_bit_end = tx_step && tx_cnt == 8'h00;
  wire tx_out_bit = msb_first ? transmit_shift_register[7] :
                    transmit_shift_register[0];
  wire [7:0] tx_shifted = msb_first ? {transmit_shift_register[6:0], 1'b0} :
                          {1'b0, transmit_shift_register[7:1]};
  wire tx_par_bit = mode.parity == ascmc_pkg::PAR_ODD ? ~tx_par :
                    mode.parity == ascmc_pkg::PAR_EVEN ? tx_par :
                    1'b0;
  wire tx_last_stop = tx_state == ascmc_pkg::TX_STOP && tx_bit_end &&
                      !tx_stop_left;
  wire tx_first_load = tx_state == ascmc_pkg::TX_IDLE && tx_full && tx_step;
  wire tx_chain_load = tx_last_stop && tx_full;
  wire tx_load = tx_first_load || tx_chain_load;
  wire [7:0] bit_reload = baud_divisor - 8'h01;

  // transmit buffer contents, readable back
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      transmit_buffer <= ascmc_pkg::TXBUF_RESET;
    end else if (wr_tx) begin
      transmit_buffer <= next_txbuf;
    end
  end

  // buffer-full flag; a write in the load cycle keeps the flag set
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_full <= 1'b0;
    end else if (!tx_on) begin
      tx_full <= 1'b0;
    end else if (wr_tx) begin
      tx_full <= 1'b1;
    end else if (tx_load) begin
      tx_full <= 1'b0;
    end
  end

  // frame sequencer; the pin changes on a base clock tick, except that disabling drives it high at once
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_state <= ascmc_pkg::TX_IDLE;
      tx_cnt <= 8'h00;
      transmit_shift_register <= 8'hff;
      tx_bits <= 4'h0;
      tx_par <= 1'b0;
      tx_stop_left <= 1'b0;
      transmit_pin <= 1'b1;
    end else if (!tx_on) begin
      tx_state <= ascmc_pkg::TX_IDLE;
      tx_cnt <= 8'h00;
      tx_bits <= 4'h0;
      tx_par <= 1'b0;
      tx_stop_left <= 1'b0;
      transmit_pin <= 1'b1;
    end else if (tx_load) begin
      tx_state <= ascmc_pkg::TX_START;
      transmit_shift_register <= transmit_buffer;
      tx_cnt <= bit_reload;
      tx_bits <= 4'h0;
      tx_par <= 1'b0;
      transmit_pin <= 1'b0;
    end else if (tx_step) begin
      tx_cnt <= tx_bit_end ? bit_reload : tx_cnt - 8'h01;
      if (tx_bit_end) begin
        unique case (tx_state)
          ascmc_pkg::TX_IDLE: begin
            transmit_pin <= 1'b1;
          end
          ascmc_pkg::TX_START, ascmc_pkg::TX_DATA: begin
            if (tx_bits == nbits) begin
              tx_state <= par_on ? ascmc_pkg::TX_PAR :
                          ascmc_pkg::TX_STOP;
              transmit_pin <= par_on ? tx_par_bit : 1'b1;
              tx_stop_left <= mode.stop2;
            end else begin
              tx_state <= ascmc_pkg::TX_DATA;
              transmit_pin <= tx_out_bit;
              tx_par <= tx_par ^ tx_out_bit;
              transmit_shift_register <= tx_shifted;
              tx_bits <= tx_bits + 4'h1;
            end
          end
          ascmc_pkg::TX_PAR: begin
            tx_state <= ascmc_pkg::TX_STOP;
            transmit_pin <= 1'b1;
          end
          ascmc_pkg::TX_STOP: begin
            if (tx_stop_left) begin
              tx_stop_left <= 1'b0;
            end else begin
              tx_state <= ascmc_pkg::TX_IDLE;
            end
          end
        endcase
      end
    end
  end

  // done pulse issued as the last stop bit ends, in the same cycle as any chained load
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      transmit_complete_interrupt <= 1'b0;
      transmit_busy <= 1'b0;
      transmit_buffer_full_flag <= 1'b0;
    end else begin
      transmit_complete_interrupt <= tx_on && tx_last_stop;
      transmit_busy <= tx_on && (tx_state != ascmc_pkg::TX_IDLE ||
                                 tx_load);
      transmit_buffer_full_flag <= tx_on && (wr_tx ||
                                             (tx_full && !tx_load));
    end
  end

  // ---------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------
  ascmc_pkg::ascmc_rx_e rx_state;
  logic [7:0] rx_cnt;
  logic [7:0] receive_shift_register;
  logic [3:0] rx_bits;
  logic rx_par;
  logic rx_unread;
  wire rx_step = base_tick && baud_ok;
  wire rx_sample = rx_step && rx_cnt == 8'h00;
  wire [7:0] rx_shifted = msb_first ? {receive_shift_register[6:0], rxd} :
                          {rxd, receive_shift_register[7:1]};
  // a 7-bit character sits one place off in the shifter
  wire [7:0] rx_word = mode.char8 ? receive_shift_register :
                       msb_first ? {receive_shift_register[6:0], 1'b0} :
                       {1'b0, receive_shift_register[7:1]};
  wire rx_par_bad = (mode.parity == ascmc_pkg::PAR_ODD && !(rx_par ^ rxd)) ||
                    (mode.parity == ascmc_pkg::PAR_EVEN && (rx_par ^ rxd));
  wire rx_done = rx_state == ascmc_pkg::RX_STOP && rx_sample;
  wire frm_err = !rxd;
  wire ovr_err = rx_unread;
  logic rx_perr;
  wire any_err = frm_err || ovr_err || rx_perr;

  // only the first stop bit is ever sampled
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rx_state <= ascmc_pkg::RX_IDLE;
      rx_cnt <= 8'h00;
      receive_shift_register <= 8'hff;
      rx_bits <= 4'h0;
      rx_par <= 1'b0;
      rx_perr <= 1'b0;
    end else if (!rx_on) begin
      rx_state <= ascmc_pkg::RX_IDLE;
      rx_cnt <= 8'h00;
      rx_bits <= 4'h0;
      rx_par <= 1'b0;
      rx_perr <= 1'b0;
    end else if (rx_step) begin
      rx_cnt <= rx_sample ? bit_reload : rx_cnt - 8'h01;
      unique case (rx_state)
        ascmc_pkg::RX_IDLE: begin
          // a level already low at enable counts as a start bit
          if (!rxd) begin
            rx_state <= ascmc_pkg::RX_START;
            // one less than half a bit, so the confirm lands mid start bit
            rx_cnt <= {1'b0, baud_divisor[7:1]} - 8'h01;
            rx_bits <= 4'h0;
            rx_par <= 1'b0;
            rx_perr <= 1'b0;
          end
        end
        ascmc_pkg::RX_START: begin
          if (rx_sample) begin
            rx_state <= rxd ? ascmc_pkg::RX_IDLE :
                        ascmc_pkg::RX_DATA;
          end
        end
        ascmc_pkg::RX_DATA: begin
          if (rx_sample) begin
            receive_shift_register <= rx_shifted;
            rx_par <= rx_par ^ rxd;
            rx_bits <= rx_bits + 4'h1;
            if (rx_bits + 4'h1 == nbits) begin
              rx_state <= par_on ? ascmc_pkg::RX_PAR :
                          ascmc_pkg::RX_STOP;
            end
          end
        end
        ascmc_pkg::RX_PAR: begin
          if (rx_sample) begin
            rx_perr <= rx_par_bad;
            rx_state <= ascmc_pkg::RX_STOP;
          end
        end
        ascmc_pkg::RX_STOP: begin
          if (rx_sample) begin
            rx_state <= ascmc_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  // buffer cleared by power-down, never written by software
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      receive_buffer <= ascmc_pkg::RXBUF_RESET;
    end else if (!power) begin
      receive_buffer <= ascmc_pkg::RXBUF_RESET;
    end else if (rx_on && rx_done && !ovr_err) begin
      receive_buffer <= rx_word;
    end
  end

  // unread marker; a new character wins over a same-cycle read
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rx_unread <= 1'b0;
    end else if (!rx_on) begin
      rx_unread <= 1'b0;
    end else if (rx_done && !ovr_err) begin
      rx_unread <= 1'b1;
    end else if (rd_rx) begin
      rx_unread <= 1'b0;
    end
  end

  // error flags sticky until read; a new error beats the clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      overrun_error_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      framing_error_flag <= 1'b0;
    end else if (!rx_on) begin
      overrun_error_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      framing_error_flag <= 1'b0;
    end else if (rx_done) begin
      overrun_error_flag <= ovr_err || (overrun_error_flag &&
                                        !error_status_read);
      parity_error_flag <= rx_perr || (parity_error_flag &&
                                       !error_status_read);
      framing_error_flag <= frm_err || (framing_error_flag &&
                                        !error_status_read);
    end else if (error_status_read) begin
      overrun_error_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      framing_error_flag <= 1'b0;
    end
  end

  // error routed to exactly one of the two receive interrupts
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      receive_complete_interrupt <= 1'b0;
      receive_error_interrupt <= 1'b0;
    end else begin
      receive_complete_interrupt <= rx_on && rx_done &&
                                    (!any_err || mode.err_route);
      receive_error_interrupt <= rx_on && rx_done && any_err &&
                                 !mode.err_route;
    end
  end

endmodule

// >>> bench/ascmc_checker.sv
`timescale 1ns/1ps
module ascmc_checker (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_wmask,
  input wire logic bus_we,
  input wire logic bus_re,
  input wire logic [7:0] bus_rdata,
  input wire logic transmit_pin,
  input wire logic transmit_buffer_full_flag,
  input wire logic transmit_busy,
  input wire logic overrun_error_flag,
  input wire logic parity_error_flag,
  input wire logic framing_error_flag,
  input wire logic transmit_complete_interrupt,
  input wire logic receive_complete_interrupt,
  input wire logic receive_error_interrupt
);
  ascmc_pkg::ascmc_mode_s mode;
  wire mode_hit = bus_addr == ascmc_pkg::MODE_ADDR;
  wire tx_hit = bus_addr == ascmc_pkg::TXBUF_ADDR;
  wire mapped = mode_hit || tx_hit || bus_addr == ascmc_pkg::RXBUF_ADDR;
  wire tx_on = mode.power && mode.tx_en;
  wire rx_on = mode.power && mode.rx_en;

  // shadow of the mode register; checks follow software's settings
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mode <= ascmc_pkg::ascmc_mode_s'(ascmc_pkg::MODE_RESET);
    end else if (bus_we && mode_hit) begin
      mode <= ascmc_pkg::ascmc_mode_s'((mode & ~bus_wmask) |
                                       (bus_wdata & bus_wmask));
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------
  // register side
  // ----------------------------------------
  a_mode_readback: assert property (bus_re && mode_hit && !bus_we
    |=> bus_rdata == $past(mode)) else $error("mode readback wrong");
  a_unmapped_zero: assert property (bus_re && !mapped
    |=> bus_rdata == 8'h00) else $error("unmapped read not zero");

  // ----------------------------------------
  // transmit side
  // ----------------------------------------
  a_power_pin_high: assert property (!mode.power |=> transmit_pin)
    else $error("pin low while powered off");
  a_tx_off_idle: assert property (!tx_on
    |=> !transmit_busy && !transmit_buffer_full_flag && transmit_pin)
    else $error("transmitter active while disabled");
  a_start_enabled: assert property ($fell(transmit_pin)
    |-> $past(tx_on)) else $error("start bit while disabled");
  a_tx_start_soon: assert property (bus_we && tx_hit && tx_on
    && !transmit_busy |-> ##[1:8] transmit_busy)
    else $error("write did not start frame");
  a_txc_after_stop: assert property (transmit_complete_interrupt
    |-> $past(transmit_pin) ##1 !transmit_complete_interrupt)
    else $error("frame done pulse wrong");

  // ----------------------------------------
  // receive side
  // ----------------------------------------
  a_rx_off_clear: assert property (!rx_on |=> !overrun_error_flag &&
    !parity_error_flag && !framing_error_flag)
    else $error("error flags kept while rx off");
  a_err_route: assert property (receive_error_interrupt
    |-> !$past(mode.err_route) && !receive_complete_interrupt)
    else $error("error interrupt misrouted");
  a_parity_kind: assert property ($rose(parity_error_flag)
    |-> $past(mode.parity[1])) else $error("parity flagged unchecked");
endmodule

bind ascmc_core ascmc_checker chk_u (.clock, .arst_n, .bus_addr,
  .bus_wdata, .bus_wmask, .bus_we, .bus_re, .bus_rdata, .transmit_pin,
  .transmit_buffer_full_flag, .transmit_busy, .overrun_error_flag,
  .parity_error_flag, .framing_error_flag, .transmit_complete_interrupt,
  .receive_complete_interrupt, .receive_error_interrupt);

// >>> bench/ascmc_remote_node.sv
`timescale 1ns/1ps
module ascmc_remote_node (
  input wire logic clock,
  input wire logic base_tick,
  input wire logic [7:0] baud_divisor,
  input wire logic [3:0] cap_len,
  input wire logic line_in,
  output logic line_out,
  output logic [11:0] cap,
  output logic [7:0] cap_count
);
  initial begin
    line_out = 1'b1;
    cap = 12'hfff;
    cap_count = 8'h00;
  end

  task automatic ticks(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock iff base_tick);
    end
  endtask

  // bits change right after a tick edge so each lasts exactly k ticks
  task automatic send(input logic [11:0] f, input int n);
    ticks(1);
    for (int i = 0; i < n; i++) begin
      line_out <= f[i];
      ticks(baud_divisor);
    end
    line_out <= 1'b1;
  endtask

  // mid-bit sampler; cap_len counts start through stop bits
  initial forever begin
    logic [11:0] t;
    @(posedge clock iff (base_tick && !line_in));
    t = 12'hfff;
    t[0] = 1'b0;
    ticks(baud_divisor / 2);
    for (int i = 1; i < cap_len; i++) begin
      ticks(baud_divisor);
      t[i] = line_in;
    end
    cap = t;
    cap_count = cap_count + 8'h01;
    @(posedge clock iff line_in);
  end
endmodule

// >>> bench/async_serial_core_mode_control_test.sv
`timescale 1ns/1ps
module async_serial_core_mode_control_test;
  localparam logic [7:0] MODES [4] = '{8'he4, 8'hea, 8'hf4, 8'hfa};
  localparam logic [7:0] DATS [4] = '{8'ha5, 8'hb4, 8'h3c, 8'h69};
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0] bus_wdata = 8'h00;
  logic [7:0] bus_wmask = 8'hff;
  logic bus_we = 1'b0;
  logic bus_re = 1'b0;
  logic base_tick = 1'b0;
  logic [7:0] baud_divisor = 8'h04;
  logic msb_first = 1'b0;
  logic error_status_read = 1'b0;
  logic [3:0] cap_len = 4'ha;
  logic [7:0] bus_rdata, cap_count, c0;
  logic receive_pin, transmit_pin, transmit_buffer_full_flag;
  logic transmit_busy, overrun_error_flag, parity_error_flag;
  logic framing_error_flag, transmit_complete_interrupt;
  logic receive_complete_interrupt, receive_error_interrupt;
  logic [11:0] cap, fr;
  int fl;
  logic [1:0] irq_seen = 2'h0;
  int num_errors = 0;
  int n_compared = 0;

  ascmc_core dut_u (.clock, .arst_n, .bus_addr, .bus_wdata, .bus_wmask,
    .bus_we, .bus_re, .bus_rdata, .base_tick, .baud_divisor, .msb_first,
    .error_status_read, .receive_pin, .transmit_pin,
    .transmit_buffer_full_flag, .transmit_busy, .overrun_error_flag,
    .parity_error_flag, .framing_error_flag, .transmit_complete_interrupt,
    .receive_complete_interrupt, .receive_error_interrupt);
  ascmc_remote_node partner_u (.clock, .base_tick, .baud_divisor, .cap_len,
    .line_in(transmit_pin), .line_out(receive_pin), .cap, .cap_count);

  // ----------------------------------------
  // clocks and helpers
  // ----------------------------------------
  initial forever #2.5 clock = ~clock;
  always @(negedge clock) base_tick <= ~base_tick;

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string w, input logic [11:0] e,
                     input logic [11:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic [7:0] m = 8'hff);
    @(negedge clock);
    bus_addr = a;
    bus_wdata = d;
    bus_wmask = m;
    bus_we = 1'b1;
    @(negedge clock);
    bus_we = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string w);
    @(negedge clock);
    bus_addr = a;
    bus_re = 1'b1;
    @(negedge clock);
    bus_re = 1'b0;
    chk(w, e, bus_rdata);
  endtask

  // bounded waits: a hang counts as a mismatch and ends the run
  task automatic wait_rx();
    int i;
    for (i = 0; i < 3000 && !(receive_complete_interrupt === 1'b1 ||
         receive_error_interrupt === 1'b1); i++) @(negedge clock);
    irq_seen = {receive_complete_interrupt, receive_error_interrupt};
    if (i == 3000) begin
      num_errors++;
      conclude();
    end
  endtask

  task automatic wait_cap(input logic [7:0] o);
    int i;
    for (i = 0; i < 3000 && cap_count == o; i++) @(negedge clock);
    if (i == 3000) begin
      num_errors++;
      conclude();
    end
  endtask

  task automatic rx_frame(input logic [11:0] f, input int n);
    fork
      partner_u.send(f, n);
      wait_rx();
    join
  endtask

  // expected wire image: start, data, parity, stops; bit 0 goes first
  function automatic logic [11:0] mk(input logic [7:0] d, input logic [7:0] m,
                                     output int n);
    logic [11:0] f;
    logic p;
    f = 12'hffe;
    p = 1'b0;
    n = 1;
    for (int i = 0; i < (m[2] ? 8 : 7); i++) begin
      f[n] = msb_first ? d[7 - i] : d[i];
      p = p ^ f[n];
      n++;
    end
    if (m[4:3] != ascmc_pkg::PAR_NONE) begin
      f[n] = (m[4:3] == ascmc_pkg::PAR_ZERO) ? 1'b0 :
             (m[4:3] == ascmc_pkg::PAR_ODD) ? ~p : p;
      n++;
    end
    n = n + (m[1] ? 2 : 1);
    return f;
  endfunction

  function automatic logic [7:0] rxv(input logic [7:0] d, input logic [7:0] m);
    return m[2] ? d : msb_first ? {d[7:1], 1'b0} : {1'b0, d[6:0]};
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(negedge clock);
    arst_n = 1'b1;
    rd(ascmc_pkg::MODE_ADDR, ascmc_pkg::MODE_RESET, "mode");
    rd(ascmc_pkg::TXBUF_ADDR, ascmc_pkg::TXBUF_RESET, "tx buffer");
    wr(ascmc_pkg::RXBUF_ADDR, 8'h00);
    rd(ascmc_pkg::RXBUF_ADDR, ascmc_pkg::RXBUF_RESET, "rx buffer");
    rd(16'hff5f, 8'h00, "unmapped");
    wr(ascmc_pkg::MODE_ADDR, 8'h80, 8'h80);
    rd(ascmc_pkg::MODE_ADDR, 8'h81, "mode bit write");
    $display("test registers done");
    // every parity code, both lengths, both orders, one and two stops
    for (int i = 0; i < 4; i++) begin
      wr(ascmc_pkg::MODE_ADDR, 8'h80);
      msb_first = i[0];
      wr(ascmc_pkg::MODE_ADDR, MODES[i]);
      fr = mk(DATS[i], MODES[i], fl);
      cap_len = fl[3:0];
      c0 = cap_count;
      wr(ascmc_pkg::TXBUF_ADDR, DATS[i]);
      wait_cap(c0);
      chk("tx frame", fr, cap);
      rx_frame(fr, fl);
      rd(ascmc_pkg::RXBUF_ADDR, rxv(DATS[i], MODES[i]), "rx data");
      chk("rx irq", 2'b10, irq_seen);
    end
    // second byte written once the first sits in the shifter, no gap
    c0 = cap_count;
    wr(ascmc_pkg::TXBUF_ADDR, 8'h96);
    for (int j = 0; j < 40 && transmit_buffer_full_flag !== 1'b0; j++)
      @(negedge clock);
    chk("buffer flag", 1'b0, transmit_buffer_full_flag);
    wr(ascmc_pkg::TXBUF_ADDR, 8'h0f);
    wait_cap(c0);
    chk("tx first", mk(8'h96, MODES[3], fl), cap);
    wait_cap(c0 + 8'h01);
    chk("tx chained", mk(8'h0f, MODES[3], fl), cap);
    $display("test formats done");
    rx_frame(fr ^ 12'h100, fl);
    chk("parity flag", 1'b1, parity_error_flag);
    chk("error irq", 2'b01, irq_seen);
    rd(ascmc_pkg::RXBUF_ADDR, rxv(DATS[3], MODES[3]), "rx bad parity");
    @(negedge clock) error_status_read = 1'b1;
    @(negedge clock) error_status_read = 1'b0;
    chk("parity clear", 1'b0, parity_error_flag);
    wr(ascmc_pkg::MODE_ADDR, 8'h80);
    wr(ascmc_pkg::MODE_ADDR, 8'hea);
    fr = mk(8'h5a, 8'hea, fl);
    rx_frame(fr ^ 12'h100, fl);
    chk("zero parity", 1'b0, parity_error_flag);
    fr = mk(8'h33, 8'hea, fl);
    rx_frame(fr, fl);
    chk("overrun flag", 1'b1, overrun_error_flag);
    rd(ascmc_pkg::RXBUF_ADDR, rxv(8'h5a, 8'hea), "rx kept");
    // low stop bit with errors routed to the receive-complete pulse
    wr(ascmc_pkg::MODE_ADDR, 8'h80);
    wr(ascmc_pkg::MODE_ADDR, 8'he5);
    fr = mk(8'hc3, 8'he5, fl);
    rx_frame(fr ^ 12'h200, fl);
    chk("framing flag", 1'b1, framing_error_flag);
    chk("routed irq", 2'b10, irq_seen);
    $display("test errors done");
    wr(ascmc_pkg::MODE_ADDR, 8'h80);
    wr(ascmc_pkg::MODE_ADDR, 8'h00);
    rd(ascmc_pkg::RXBUF_ADDR, 8'hff, "rx after off");
    chk("pin off", 1'b1, transmit_pin);
    $display("test power off done");
    conclude();
  end
endmodule
